/* ifl_consts.svh */
// Constants of the infrared frame length, flow control and frame status block
// Functional notes
// - TX length is 13 bits, used when auto package set
// - Long TX data is split into programmed-length frames
// - TX length read returns bytes not yet sent
// - RX length is a 13-bit limit with up counter
// - Over-length frame flags and blocks until next start
// - RX length read returns bytes received this frame
// - Flow control copies flow divisor to advanced divisor
// - Flow mode bits 7..5 load advanced mode field
// - Swap bit 3 picks receiver or transmitter DMA
// - Bit 2 lets DMA be used under flow control
// - Bit 1 enables flow divisor reload
// - Bit 0 enables flow control and bits 7..1
// - Set select write picks set, reads ECH (E8H in set 4)
// - Threshold bit gives status level 2 or 4
// - Config bit 5 splits TX into equal frames
// - Config bit 4 selects auxiliary receive pin
// - Handshake disable bit only drives HSR_DISABLE_O
// - Config bit 0 picks half or full duplex
// - Status read shows queue bottom, bit 7 valid
// - Bit 6 set when received frames are lost
// - Entry holds exceeded, physical and CRC error flags
// - Bit 1 RX FIFO overrun, bit 0 queue overrun
// - Length high read pops next entry when valid
`ifndef IFL_CONSTS_SVH
`define IFL_CONSTS_SVH
// ****************************************
// Register sets and indices
// ****************************************
`define IFL_SET_TX 3'h4
`define IFL_SET_FC 3'h5
`define IFL_IDX_FCB_LO 3'h0
`define IFL_IDX_FCB_HI 3'h1
`define IFL_IDX_FLOW_CONTROL_MODE 3'h2
`define IFL_IDX_SSR 3'h3
`define IFL_IDX_TX_LO 3'h4
`define IFL_IDX_TX_HI 3'h5
`define IFL_IDX_RX_LO 3'h6
`define IFL_IDX_RX_HI 3'h7
`define IFL_IDX_CFG 3'h4
`define IFL_IDX_FS 3'h5
`define IFL_IDX_LF_LO 3'h6
`define IFL_IDX_LF_HI 3'h7
// ****************************************
// Fixed read values, masks and resets
// ****************************************
`define IFL_SSR_RD_FC 8'hEC
`define IFL_SSR_RD_TX 8'hE8
`define IFL_HSR_OFF 8'h30
`define IFL_FC_MASK 8'hEF
`define IFL_CFG_MASK 8'h73
`define IFL_RST8 8'h00
`define IFL_RST_BANK 3'h0
// ****************************************
// Field positions
// ****************************************
`define IFL_FC_EN 0
`define IFL_FC_BAUD 1
`define IFL_FC_DMA 2
`define IFL_FC_SWAP 3
`define IFL_FC_MODE_LO 5
`define IFL_CFG_DUPLEX 0
`define IFL_CFG_HSDIS 1
`define IFL_CFG_AUX 4
`define IFL_CFG_SPLIT 5
`define IFL_CFG_TH 6
`define IFL_TH_LOW 2
`define IFL_TH_HIGH 4
`endif

/* ifl_pkg.sv */
// Types of the infrared frame length block
package ifl_pkg;
  typedef logic [12:0] ifl_len_t;
  typedef logic [2:0] ifl_flags_t;
endpackage : ifl_pkg

/* ifl_top.sv */
// Infrared frame length, flow control and frame status logic with APB slave
`timescale 1ns/1ps
`include "ifl_consts.svh"
module ifl_top
  import ifl_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Receive pins
  input wire logic IR_RX_I,
  input wire logic AUX_RX_I,
  output logic RX_DATA_O,
  // Physical layer events
  input wire logic TX_BYTE_I,
  input wire logic RX_START_I,
  input wire logic RX_BYTE_I,
  input wire logic RX_END_I,
  input wire logic RX_PHYSICAL_LAYER_FAULT_FLAG_I,
  input wire logic RX_CRC_ERR_I,
  input wire logic RX_FIFO_OVF_I,
  input wire logic MODE_TO_SIR_I,
  // Physical layer controls
  output logic TX_FRAME_END_O,
  output logic RX_WRITE_O,
  output logic [15:0] ADV_DIV_O,
  output logic [2:0] ADV_MODE_O,
  output logic DMA_ENABLE_O,
  output logic DMA_TX_SEL_O,
  output logic HSR_DISABLE_O,
  output logic FULL_DUPLEX_O,
  output logic FSF_INT_O
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic sel(input logic [2:0] b, input logic [2:0] x,
                               input logic [2:0] s, input logic [2:0] i);
    return (b == s) && (x == i);
  endfunction : sel

  logic [2:0] bank;
  logic [7:0] fcb_lo;
  logic [7:0] fcb_hi;
  logic [7:0] flow_control_mode;
  logic [7:0] cfg;
  logic [7:0] tx_lo;
  logic [7:0] tx_hi;
  logic [7:0] rx_lo;
  logic [7:0] rx_hi;
  ifl_len_t tx_rem;
  ifl_len_t rx_cnt;
  logic rx_block;
  logic rx_lex;
  logic receive_fifo_overflow_flag;
  logic fs_ov;
  logic lost;
  logic [7:0] lost_cnt;
  logic [7:0] st_mem [DEPTH];
  ifl_len_t ln_mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic ir_s1;
  logic ir_s2;
  logic aux_s1;
  logic aux_s2;

  wire [2:0] idx = PADDR_I[4:2];
  wire in_map = (PADDR_I[11:5] == 7'h00) && (PADDR_I[1:0] == 2'b00);
  wire acc = PSEL_I && PENABLE_I && PREADY_O;
  wire wr = acc && PWRITE_I && in_map;
  wire rd = acc && !PWRITE_I && in_map;
  wire [7:0] wd = PWDATA_I[7:0];
  wire h_ssr = (idx == `IFL_IDX_SSR);
  wire h_fcl = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_FCB_LO);
  wire h_fch = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_FCB_HI);
  wire h_fcm = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_FLOW_CONTROL_MODE);
  wire h_cfg = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_CFG);
  wire h_fs = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_FS);
  wire h_lfl = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_LF_LO);
  wire h_lfh = sel(bank, idx, `IFL_SET_FC, `IFL_IDX_LF_HI);
  wire h_txl = sel(bank, idx, `IFL_SET_TX, `IFL_IDX_TX_LO);
  wire h_txh = sel(bank, idx, `IFL_SET_TX, `IFL_IDX_TX_HI);
  wire h_rxl = sel(bank, idx, `IFL_SET_TX, `IFL_IDX_RX_LO);
  wire h_rxh = sel(bank, idx, `IFL_SET_TX, `IFL_IDX_RX_HI);
  wire wr_tx = wr && (h_txl || h_txh);

  // ****************************************
  // Derived controls
  // ****************************************
  // combined transmit length
  wire ifl_len_t tx_len = {tx_hi[4:0], tx_lo};
  wire ifl_len_t next_tx_len = h_txl ? {tx_hi[4:0], wd} : {wd[4:0], tx_lo};
  wire ifl_len_t rx_lim = {rx_hi[4:0], rx_lo};
  wire split_en = cfg[`IFL_CFG_SPLIT];
  wire fc_on = flow_control_mode[`IFL_FC_EN];
  wire fc_evt = MODE_TO_SIR_I && fc_on;
  wire full = (cnt == (AW + 1)'(DEPTH));
  wire empty = (cnt == '0);
  wire push_ok = RX_END_I && !full;
  wire push_bad = RX_END_I && full;
  wire pop = rd && h_lfh && !empty;
  wire rx_take = RX_BYTE_I && !rx_block && !RX_START_I;
  wire rx_over = rx_take && (rx_cnt >= rx_lim);
  wire rx_ok = rx_take && !rx_over;
  wire tx_end = split_en && TX_BYTE_I && !wr_tx && (tx_rem <= 13'd1);
  wire [AW:0] lvl = cfg[`IFL_CFG_TH] ? (AW + 1)'(`IFL_TH_HIGH) : (AW + 1)'(`IFL_TH_LOW);
  wire clr_fs = rd && h_fs;
  wire [7:0] bottom = st_mem[rp];
  wire ifl_len_t bot_len = ln_mem[rp];
  wire [AW:0] next_cnt = cnt + (AW + 1)'(push_ok) - (AW + 1)'(pop);

  // ****************************************
  // Read multiplexer
  // ****************************************
  // queue bottom with valid, lost, overruns
  wire [7:0] fs_rd = {!empty, lost, 1'b0, empty ? 3'b000 : bottom[4:2], receive_fifo_overflow_flag, fs_ov};
  wire [7:0] ssr_rd = (bank == `IFL_SET_TX) ? `IFL_SSR_RD_TX : `IFL_SSR_RD_FC;
  wire [7:0] rd_b =
    h_ssr ? ssr_rd :
    h_fcl ? fcb_lo :
    h_fch ? fcb_hi :
    h_fcm ? flow_control_mode :
    h_cfg ? cfg :
    h_fs ? fs_rd :
    h_lfl ? (lost ? lost_cnt : bot_len[7:0]) :
    h_lfh ? {3'b000, bot_len[12:8]} :
    h_txl ? tx_rem[7:0] :
    h_txh ? {3'b000, tx_rem[12:8]} :
    h_rxl ? rx_cnt[7:0] :
    h_rxh ? {3'b000, rx_cnt[12:8]} : `IFL_RST8;
  wire next_ready = PSEL_I && PENABLE_I && !PREADY_O;

  // ****************************************
  // APB handshake
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= next_ready;
      PSLVERR_O <= next_ready && !in_map;
      if (next_ready) begin
        PRDATA_O <= {24'h00_0000, in_map ? rd_b : `IFL_RST8};
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      bank <= `IFL_RST_BANK;
      fcb_lo <= `IFL_RST8;
      fcb_hi <= `IFL_RST8;
      flow_control_mode <= `IFL_RST8;
      cfg <= `IFL_RST8;
      tx_lo <= `IFL_RST8;
      tx_hi <= `IFL_RST8;
      rx_lo <= `IFL_RST8;
      rx_hi <= `IFL_RST8;
    end else if (wr) begin
      if (h_ssr) bank <= wd[2:0];
      if (h_fcl) fcb_lo <= wd;
      if (h_fch) fcb_hi <= wd;
      if (h_fcm) flow_control_mode <= wd & `IFL_FC_MASK;
      if (h_cfg) cfg <= wd & `IFL_CFG_MASK;
      if (h_txl) tx_lo <= wd;
      if (h_txh) tx_hi <= {3'b000, wd[4:0]};
      if (h_rxl) rx_lo <= wd;
      if (h_rxh) rx_hi <= {3'b000, wd[4:0]};
    end
  end

  // ****************************************
  // Transmit frame splitting
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tx_rem <= '0;
      TX_FRAME_END_O <= 1'b0;
    end else begin
      TX_FRAME_END_O <= tx_end;
      if (wr_tx) begin
        tx_rem <= next_tx_len;
      end else if (tx_end) begin
        tx_rem <= tx_len;
      end else if (split_en && TX_BYTE_I) begin
        tx_rem <= tx_rem - 13'd1;
      end
    end
  end

  // ****************************************
  // Receive length limit
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rx_cnt <= '0;
      rx_block <= 1'b0;
      rx_lex <= 1'b0;
      RX_WRITE_O <= 1'b0;
    end else begin
      RX_WRITE_O <= rx_ok;
      // next start flag reopens the FIFO
      if (RX_START_I) begin
        rx_cnt <= '0;
        rx_block <= 1'b0;
        rx_lex <= 1'b0;
      end else if (rx_over) begin
        rx_block <= 1'b1;
        rx_lex <= 1'b1;
      end else if (rx_ok) begin
        rx_cnt <= rx_cnt + 13'd1;
      end
    end
  end

  // ****************************************
  // Frame status queue
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (push_ok) begin
      st_mem[wp] <= {3'b000, rx_lex || rx_over, RX_PHYSICAL_LAYER_FAULT_FLAG_I, RX_CRC_ERR_I, 2'b00};
      ln_mem[wp] <= rx_cnt;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push_ok) wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
      if (pop) rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
      cnt <= next_cnt;
    end
  end

  // Sticky flags: a new event wins over the clearing read
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      receive_fifo_overflow_flag <= 1'b0;
      fs_ov <= 1'b0;
      lost <= 1'b0;
      lost_cnt <= `IFL_RST8;
    end else begin
      receive_fifo_overflow_flag <= RX_FIFO_OVF_I || (receive_fifo_overflow_flag && !clr_fs);
      fs_ov <= push_bad || (fs_ov && !clr_fs);
      lost <= push_bad || (lost && !clr_fs);
      if (push_bad) begin
        lost_cnt <= (clr_fs ? `IFL_RST8 : lost_cnt) + 8'h01;
      end else if (clr_fs) begin
        lost_cnt <= `IFL_RST8;
      end
    end
  end

  // ****************************************
  // Flow control and configuration outputs
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ADV_DIV_O <= 16'h0000;
      ADV_MODE_O <= 3'h0;
      DMA_ENABLE_O <= 1'b0;
      DMA_TX_SEL_O <= 1'b0;
      HSR_DISABLE_O <= 1'b0;
      FULL_DUPLEX_O <= 1'b0;
      FSF_INT_O <= 1'b0;
    end else begin
      // flow control acts only while enabled
      if (fc_evt) begin
        if (flow_control_mode[`IFL_FC_BAUD]) ADV_DIV_O <= {fcb_hi, fcb_lo};
        ADV_MODE_O <= flow_control_mode[`IFL_FC_MODE_LO +: 3];
        DMA_ENABLE_O <= flow_control_mode[`IFL_FC_DMA];
        DMA_TX_SEL_O <= flow_control_mode[`IFL_FC_SWAP];
      end
      HSR_DISABLE_O <= cfg[`IFL_CFG_HSDIS];
      FULL_DUPLEX_O <= cfg[`IFL_CFG_DUPLEX];
      FSF_INT_O <= (next_cnt >= lvl);
    end
  end

  // ****************************************
  // Receive pin selection
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ir_s1 <= 1'b0;
      ir_s2 <= 1'b0;
      aux_s1 <= 1'b0;
      aux_s2 <= 1'b0;
      RX_DATA_O <= 1'b0;
    end else begin
      ir_s1 <= IR_RX_I;
      ir_s2 <= ir_s1;
      aux_s1 <= AUX_RX_I;
      aux_s2 <= aux_s1;
      RX_DATA_O <= cfg[`IFL_CFG_AUX] ? aux_s2 : ir_s2;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  property p_rx_block;
    rx_block && !RX_START_I |=> !RX_WRITE_O;
  endproperty
  a_rx_block: assert property (p_rx_block) else $error("write while blocked");

  property p_rx_limit;
    RX_WRITE_O |-> $past(rx_cnt) < $past(rx_lim);
  endproperty
  a_rx_limit: assert property (p_rx_limit) else $error("frame beyond limit");

  property p_tx_split;
    TX_FRAME_END_O |-> tx_rem == tx_len && $past(split_en);
  endproperty
  a_tx_split: assert property (p_tx_split) else $error("bad split reload");

  property p_fc_mode;
    fc_evt |=> ADV_MODE_O == $past(flow_control_mode[7:5]) && DMA_TX_SEL_O == $past(flow_control_mode[3]);
  endproperty
  a_fc_mode: assert property (p_fc_mode) else $error("mode not loaded");

  property p_fc_off;
    MODE_TO_SIR_I && !fc_on |=> $stable(ADV_DIV_O) && $stable(ADV_MODE_O);
  endproperty
  a_fc_off: assert property (p_fc_off) else $error("flow acted while off");

  property p_baud;
    fc_evt && flow_control_mode[1] |=> ADV_DIV_O == $past({fcb_hi, fcb_lo});
  endproperty
  a_baud: assert property (p_baud) else $error("divisor not reloaded");

  property p_pop;
    pop && !push_ok |=> cnt == $past(cnt) - 1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop missed");

  property p_ssr;
    next_ready && in_map && !PWRITE_I && h_ssr && bank == `IFL_SET_FC
      |=> PRDATA_O[7:0] == 8'hEC;
  endproperty
  a_ssr: assert property (p_ssr) else $error("bad set select read");

  property p_ovf;
    RX_FIFO_OVF_I |=> receive_fifo_overflow_flag ##1 PREADY_O || receive_fifo_overflow_flag || $past(clr_fs);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun lost");

  property p_lost;
    push_bad |=> lost && fs_ov && (cnt + (AW + 1)'($past(pop))) == (AW + 1)'(DEPTH);
  endproperty
  a_lost: assert property (p_lost) else $error("lost frame not flagged");
endmodule : ifl_top

/* ifl_optics.sv */
// Infrared transceiver and physical layer event model
`timescale 1ns/1ps
module ifl_optics (
  // Clock
  input wire logic clk_i,
  // Receive pins
  output logic ir_rx_o,
  output logic aux_rx_o,
  // Physical layer events
  output logic tx_byte_o,
  output logic rx_start_o,
  output logic rx_byte_o,
  output logic rx_end_o,
  output logic physical_layer_fault_flag_o,
  output logic crc_err_o,
  output logic ovf_o,
  output logic to_sir_o
);
  logic tog = 1'b0;
  logic hold = 1'b0;
  logic pv = 1'b0;
  logic cv = 1'b0;
  // ****************************************
  // Error levels carry meaning only with frame end
  // ****************************************
  assign physical_layer_fault_flag_o = hold ? pv : tog;
  assign crc_err_o = hold ? cv : ~tog;
  always @(posedge clk_i) tog <= ~tog;
  initial begin
    {ir_rx_o, aux_rx_o, tx_byte_o, rx_start_o} = 4'h0;
    {rx_byte_o, rx_end_o, ovf_o, to_sir_o} = 4'h0;
  end
  task automatic pins(input logic ir, input logic aux);
    @(posedge clk_i);
    ir_rx_o <= ir;
    aux_rx_o <= aux;
  endtask : pins
  // One-cycle event: 0 tx byte, 1 start, 2 rx byte, 3 overrun, 4 switch to slow mode
  task automatic strobe(input int k);
    @(posedge clk_i);
    tx_byte_o <= (k == 0);
    rx_start_o <= (k == 1);
    rx_byte_o <= (k == 2);
    ovf_o <= (k == 3);
    to_sir_o <= (k == 4);
    @(posedge clk_i);
    {tx_byte_o, rx_start_o, rx_byte_o, ovf_o, to_sir_o} <= 5'h00;
  endtask : strobe
  task automatic frame(input int n, input logic p, input logic c);
    strobe(1);
    repeat (n) strobe(2);
    @(posedge clk_i);
    rx_end_o <= 1'b1;
    hold <= 1'b1;
    pv <= p;
    cv <= c;
    @(posedge clk_i);
    rx_end_o <= 1'b0;
    hold <= 1'b0;
  endtask : frame
endmodule : ifl_optics

/* test_ir_frame_length_status_control.sv */
// Self-checking bench of the frame length, flow control and status block
`timescale 1ns/1ps
module test_ir_frame_length_status_control;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic r;} ifl_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, ir, aux, rxd, txb, rxs, rxb, rxe, phy, crc, ovf, sir, fend, rxw;
  wire [15:0] adiv;
  wire [2:0] amode;
  wire dmae, dmat, hsd, fdx, fint;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_fe = 0;
  int n_wr = 0;
  ifl_row_s rows[19] = '{
    '{0, 12'h00C, 8'h00, 8'hEC, 0},
    '{1, 12'h00C, 8'h04, 8'h00, 0},
    '{0, 12'h00C, 8'h00, 8'hE8, 0},
    '{0, 12'h010, 8'h00, 8'h00, 0},
    '{0, 12'h014, 8'h00, 8'h00, 0},
    '{0, 12'h018, 8'h00, 8'h00, 0},
    '{0, 12'h01C, 8'h00, 8'h00, 0},
    '{1, 12'h00C, 8'h05, 8'h00, 0},
    '{0, 12'h00C, 8'h00, 8'hEC, 0},
    '{0, 12'h000, 8'h00, 8'h00, 0},
    '{0, 12'h008, 8'h00, 8'h00, 0},
    '{1, 12'h008, 8'hFE, 8'h00, 0},
    '{0, 12'h008, 8'h00, 8'hEE, 0},
    '{0, 12'h010, 8'h00, 8'h00, 0},
    '{1, 12'h010, 8'hFF, 8'h00, 0},
    '{0, 12'h010, 8'h00, 8'h73, 0},
    '{0, 12'h020, 8'h00, 8'h00, 1},
    '{1, 12'h011, 8'h00, 8'h00, 1},
    '{0, 12'h010, 8'h00, 8'h73, 0}};
  ifl_top #(.DEPTH(8)) dut_u (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IR_RX_I(ir),
    .AUX_RX_I(aux), .RX_DATA_O(rxd), .TX_BYTE_I(txb), .RX_START_I(rxs), .RX_BYTE_I(rxb),
    .RX_END_I(rxe), .RX_PHYSICAL_LAYER_FAULT_FLAG_I(phy), .RX_CRC_ERR_I(crc), .RX_FIFO_OVF_I(ovf),
    .MODE_TO_SIR_I(sir), .TX_FRAME_END_O(fend), .RX_WRITE_O(rxw), .ADV_DIV_O(adiv),
    .ADV_MODE_O(amode), .DMA_ENABLE_O(dmae), .DMA_TX_SEL_O(dmat), .HSR_DISABLE_O(hsd),
    .FULL_DUPLEX_O(fdx), .FSF_INT_O(fint));
  ifl_optics opt_u (.clk_i(clk), .ir_rx_o(ir), .aux_rx_o(aux), .tx_byte_o(txb),
    .rx_start_o(rxs), .rx_byte_o(rxb), .rx_end_o(rxe), .physical_layer_fault_flag_o(phy), .crc_err_o(crc),
    .ovf_o(ovf), .to_sir_o(sir));
  initial begin
    forever #20 clk = ~clk;
  end
  // ****************************************
  // Pulse counters and hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (fend === 1'b1) n_fe++;
    if (rxw === 1'b1) n_wr++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) chk("pready", 0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rdc
  task automatic results();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge clk);
    chk("int in reset", fint, 0);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", rd, {24'h0, rows[i].e});
      chk("row slverr", err, rows[i].r);
    end
    $display("table done");
    opt_u.pins(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    chk("rx aux", rxd, 1);
    chk("duplex", fdx, 1);
    chk("hs off", hsd, 1);
    apb(1'b1, 12'h010, 8'h20);
    repeat (6) @(posedge clk);
    chk("rx main", rxd, 0);
    chk("half", {fdx, hsd}, 0);
    opt_u.pins(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    chk("rx main hi", rxd, 1);
    $display("config done");
    apb(1'b1, 12'h000, 8'h34);
    apb(1'b1, 12'h004, 8'h12);
    apb(1'b1, 12'h008, 8'hAF);
    opt_u.strobe(4);
    repeat (2) @(posedge clk);
    chk("div", adiv, 16'h1234);
    chk("mode", amode, 3'h5);
    chk("dma", {dmae, dmat}, 2'h3);
    apb(1'b1, 12'h008, 8'h6E);
    opt_u.strobe(4);
    repeat (2) @(posedge clk);
    chk("fc off", amode, 3'h5);
    apb(1'b1, 12'h000, 8'h00);
    apb(1'b1, 12'h008, 8'h61);
    opt_u.strobe(4);
    repeat (2) @(posedge clk);
    chk("mode2", amode, 3'h3);
    chk("dma2", {dmae, dmat}, 2'h0);
    chk("div kept", adiv, 16'h1234);
    $display("flow done");
    apb(1'b1, 12'h00C, 8'h04);
    apb(1'b1, 12'h010, 8'h03);
    apb(1'b1, 12'h014, 8'h00);
    repeat (2) opt_u.strobe(0);
    rdc("tx left", 12'h010, 8'h01);
    chk("no end", n_fe, 0);
    opt_u.strobe(0);
    repeat (2) @(posedge clk);
    chk("split end", n_fe, 1);
    rdc("tx reload", 12'h010, 8'h03);
    apb(1'b1, 12'h014, 8'hFF);
    rdc("tx hi", 12'h014, 8'h1F);
    $display("tx done");
    apb(1'b1, 12'h018, 8'h02);
    apb(1'b1, 12'h01C, 8'h00);
    n_wr = 0;
    opt_u.frame(3, 1'b0, 1'b0);
    chk("rx writes", n_wr, 2);
    rdc("rx count", 12'h018, 8'h02);
    opt_u.frame(1, 1'b1, 1'b0);
    opt_u.frame(0, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    chk("int 2", fint, 1);
    apb(1'b1, 12'h00C, 8'h05);
    apb(1'b1, 12'h010, 8'h60);
    repeat (2) @(posedge clk);
    chk("int 4", fint, 0);
    rdc("fs lex", 12'h014, 8'h90);
    rdc("len", 12'h018, 8'h02);
    rdc("pop", 12'h01C, 8'h00);
    rdc("fs phy", 12'h014, 8'h88);
    apb(1'b0, 12'h01C, 8'h00);
    rdc("fs crc", 12'h014, 8'h84);
    apb(1'b0, 12'h01C, 8'h00);
    rdc("fs empty", 12'h014, 8'h00);
    $display("rx done");
    opt_u.strobe(3);
    repeat (9) opt_u.frame(0, 1'b0, 1'b0);
    rdc("lost n", 12'h018, 8'h01);
    rdc("fs ovf", 12'h014, 8'hC3);
    rdc("fs clr", 12'h014, 8'h80);
    $display("overflow done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst div", {adiv, fint}, 0);
    rst_n <= 1'b1;
    rdc("rst ssr", 12'h00C, 8'hEC);
    apb(1'b1, 12'h00C, 8'h05);
    rdc("rst cfg", 12'h010, 8'h00);
    $display("reset done");
    results();
  end
endmodule : test_ir_frame_length_status_control
